// ==== hdl/pdsb_bank.sv ====
// Purpose: Six-byte bit-coded diagnosis status bank of a valve positioner
// Assumes: Fault sources are single-bit inputs or raw readings on clk; pins are synchronised
// Notes: Master reads by byte index; clear via a write to history_clear_param
// Functional notes
// - Diagnosis is exactly six bytes of individual status bits.
// - Bytes one to three show live conditions while they persist.
// - Live bits drop as soon as their condition disappears, no acknowledge.
// - Bytes four to six are sticky and stay set after condition ends.
// - Sticky bits clear only on reset or when master writes 32768 to the clear parameter.
// - That clearing write also drops the extension-available summary flag, unless ext_set raises it in the same cycle.
// - Byte one: option, potentiometer, loop break, span, converter, ROM, NVM, RAM.
// - Byte two: switch, feedback cal, loop cal, cycles, travel, config, temp low/high.
// - Byte two bit 4 set when stroke cycle count reaches its limit.
// - Byte two bit 1 set while board temperature is below its floor.
// - Byte two bit 0 set while board temperature is above its ceiling.
// - Byte three: output press, supply low, autostart, deviation, very low/high, low/high.
// - Byte three bit 6 set while supply pressure is below its threshold.
// - Byte three bit 4 set when deviation monitor exceeds limit for its time.
// - Byte three bit 7 set when output pressure reading is implausible.
// - Byte four holds sticky copies of byte one at identical positions.
// - Byte five holds sticky copies of byte two at identical positions.
// - Byte six holds sticky copies of byte three at identical positions.
`timescale 1ns/10ps
module pdsb_bank #(
  parameter int unsigned VAL_W = 16,
  parameter int unsigned CNT_W = 24
) (
  input wire logic clk,
  input wire logic rst_b,
  // Byte one fault sources
  input wire logic option_board_fault,
  input wire logic position_pot_fault,
  input wire logic transducer_loop_break,
  input wire logic actuator_out_of_span,
  input wire logic converter_fault,
  input wire logic rom_sum_fault,
  input wire logic nvm_sum_fault,
  input wire logic ram_test_fault,
  // Byte two sources
  input wire logic switch_input_active,
  input wire logic feedback_cal_fault,
  input wire logic loop_cal_fault,
  input wire logic [CNT_W-1:0] cycle_count,
  input wire logic [CNT_W-1:0] cycle_count_limit,
  input wire logic travel_sum_limit,
  input wire logic config_invalid,
  input wire logic signed [VAL_W-1:0] board_temp,
  input wire logic signed [VAL_W-1:0] board_temp_floor,
  input wire logic signed [VAL_W-1:0] board_temp_ceiling,
  // Byte three sources
  input wire logic output_pressure_implausible,
  input wire logic [VAL_W-1:0] supply_pressure_reading,
  input wire logic [VAL_W-1:0] supply_pressure_threshold,
  input wire logic autostart_failed,
  input wire logic [VAL_W-1:0] control_deviation,
  input wire logic [VAL_W-1:0] deviation_limit,
  input wire logic [CNT_W-1:0] deviation_time,
  input wire logic position_very_low,
  input wire logic position_very_high,
  input wire logic position_low,
  input wire logic position_high,
  // Master access
  input wire logic [2:0] rd_index,
  output logic [7:0] rd_data,
  output logic rd_error,
  input wire logic param_wr,
  input wire logic [15:0] param_wdata,
  input wire logic ext_set,
  output logic ext_available,
  output logic history_cleared
);
  typedef struct packed {
    logic [CNT_W-1:0] dev_cnt;
    logic ext_avail;
    logic cleared;
    logic [7:0] rdata;
    logic rerr;
  } pdsb_state_t;

  pdsb_state_t st_r;
  pdsb_state_t st_nxt;
  pdsb_hist_if hif ();

  logic [7:0] live_sys;
  logic [7:0] live_xsys;
  logic [7:0] live_proc;
  logic clear_hit;
  logic deviation_hit;

  function automatic logic [7:0] pdsb_pick(input logic [2:0] idx, input logic [47:0] bank);
    logic [7:0] b;
    b = 8'h00;
    unique case (idx)
      pdsb_pkg::IDX_LIVE_SYS: b = bank[7:0];
      pdsb_pkg::IDX_LIVE_XSYS: b = bank[15:8];
      pdsb_pkg::IDX_LIVE_PROC: b = bank[23:16];
      pdsb_pkg::IDX_HIST_SYS: b = bank[31:24];
      pdsb_pkg::IDX_HIST_XSYS: b = bank[39:32];
      pdsb_pkg::IDX_HIST_PROC: b = bank[47:40];
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  // Live bits are combinational so they follow their condition at once
  always_comb begin
    live_sys = 8'h00;
    live_sys[pdsb_pkg::SYS_OPTION_BOARD] = option_board_fault;
    live_sys[pdsb_pkg::SYS_POSITION_POT] = position_pot_fault;
    live_sys[pdsb_pkg::SYS_LOOP_BREAK] = transducer_loop_break;
    live_sys[pdsb_pkg::SYS_OUT_OF_SPAN] = actuator_out_of_span;
    live_sys[pdsb_pkg::SYS_CONVERTER] = converter_fault;
    live_sys[pdsb_pkg::SYS_ROM_SUM] = rom_sum_fault;
    live_sys[pdsb_pkg::SYS_NVM_SUM] = nvm_sum_fault;
    live_sys[pdsb_pkg::SYS_RAM_TEST] = ram_test_fault;
  end

  always_comb begin
    live_xsys = 8'h00;
    live_xsys[pdsb_pkg::XSYS_SWITCH_IN] = switch_input_active;
    live_xsys[pdsb_pkg::XSYS_FB_CAL] = feedback_cal_fault;
    live_xsys[pdsb_pkg::XSYS_LOOP_CAL] = loop_cal_fault;
    live_xsys[pdsb_pkg::XSYS_CYCLE_LIMIT] = (cycle_count >= cycle_count_limit);
    live_xsys[pdsb_pkg::XSYS_TRAVEL_LIMIT] = travel_sum_limit;
    live_xsys[pdsb_pkg::XSYS_BAD_CONFIG] = config_invalid;
    live_xsys[pdsb_pkg::XSYS_TEMP_LOW] = (board_temp < board_temp_floor);
    live_xsys[pdsb_pkg::XSYS_TEMP_HIGH] = (board_temp > board_temp_ceiling);
  end

  // Deviation must stay above its limit for the configured time
  assign deviation_hit = (control_deviation > deviation_limit) &&
                         (st_r.dev_cnt >= deviation_time);

  always_comb begin
    live_proc = 8'h00;
    live_proc[pdsb_pkg::PROC_OUT_PRESS] = output_pressure_implausible;
    live_proc[pdsb_pkg::PROC_SUPPLY_LOW] =
      (supply_pressure_reading < supply_pressure_threshold);
    live_proc[pdsb_pkg::PROC_AUTOSTART] = autostart_failed;
    live_proc[pdsb_pkg::PROC_DEVIATION] = deviation_hit;
    live_proc[pdsb_pkg::PROC_VERY_LOW] = position_very_low;
    live_proc[pdsb_pkg::PROC_VERY_HIGH] = position_very_high;
    live_proc[pdsb_pkg::PROC_LOW] = position_low;
    live_proc[pdsb_pkg::PROC_HIGH] = position_high;
  end

  assign clear_hit = param_wr && (param_wdata == pdsb_pkg::HISTORY_CLEAR_VALUE);

  assign hif.live = {live_proc, live_xsys, live_sys};
  assign hif.clear = clear_hit;

  pdsb_hist_latch u_hist (
    .clk(clk),
    .rst_b(rst_b),
    .hl(hif.latch)
  );

  always_comb begin
    st_nxt = st_r;
    if (control_deviation > deviation_limit) begin
      if (st_r.dev_cnt != {CNT_W{1'b1}}) begin
        st_nxt.dev_cnt = st_r.dev_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end else begin
      st_nxt.dev_cnt = '0;
    end
    // Summary flag: a new raise wins over the clear
    if (ext_set) begin
      st_nxt.ext_avail = 1'b1;
    end else if (clear_hit) begin
      st_nxt.ext_avail = 1'b0;
    end
    st_nxt.cleared = clear_hit;
    st_nxt.rdata = pdsb_pick(rd_index, {hif.hist, hif.live});
    st_nxt.rerr = (rd_index > pdsb_pkg::IDX_HIST_PROC);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_data = st_r.rdata;
  assign rd_error = st_r.rerr;
  assign ext_available = st_r.ext_avail;
  assign history_cleared = st_r.cleared;
endmodule

// ==== hdl/pdsb_hist_latch.sv ====
// Purpose: Sticky history of the three live diagnosis bytes
// Assumes: Live bits and clear are synchronous to clk
// Notes: A live bit sets its history bit and beats a clear
`timescale 1ns/10ps
module pdsb_hist_latch (
  input wire logic clk,
  input wire logic rst_b,
  pdsb_hist_if.latch hl
);
  typedef struct packed {
    logic [23:0] hist;
  } pdsb_hl_state_t;
  pdsb_hl_state_t st_r;
  pdsb_hl_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    // Set in the cycle the live bit asserts; live wins over clear
    st_nxt.hist = (hl.clear ? 24'h000000 : st_r.hist) | hl.live;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Same-cycle visibility of a newly set bit
  assign hl.hist = st_r.hist | hl.live;
endmodule

// ==== include/pdsb_hist_if.sv ====
// Purpose: Carries live bytes and clear request to the history latch
// Assumes: One clock domain
// Notes: Three live bytes in, three history bytes out
`timescale 1ns/10ps
interface pdsb_hist_if;
  logic [23:0] live;
  logic clear;
  logic [23:0] hist;
  modport bank (output live, output clear, input hist);
  modport latch (input live, input clear, output hist);
endinterface

// ==== include/pdsb_pkg.sv ====
// Purpose: Shared constants for the positioner diagnosis status bank
// Assumes: Byte-wide bank read by index 0..5
// Notes: Bit positions follow the diagnosis byte layout
package pdsb_pkg;
  localparam int unsigned BANK_BYTES = 6;
  localparam int unsigned LIVE_BYTES = 3;
  localparam logic [2:0] IDX_LIVE_SYS = 3'h0;
  localparam logic [2:0] IDX_LIVE_XSYS = 3'h1;
  localparam logic [2:0] IDX_LIVE_PROC = 3'h2;
  localparam logic [2:0] IDX_HIST_SYS = 3'h3;
  localparam logic [2:0] IDX_HIST_XSYS = 3'h4;
  localparam logic [2:0] IDX_HIST_PROC = 3'h5;
  localparam logic [15:0] HISTORY_CLEAR_VALUE = 16'h8000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // Byte one
  localparam int unsigned SYS_OPTION_BOARD = 7;
  localparam int unsigned SYS_POSITION_POT = 6;
  localparam int unsigned SYS_LOOP_BREAK = 5;
  localparam int unsigned SYS_OUT_OF_SPAN = 4;
  localparam int unsigned SYS_CONVERTER = 3;
  localparam int unsigned SYS_ROM_SUM = 2;
  localparam int unsigned SYS_NVM_SUM = 1;
  localparam int unsigned SYS_RAM_TEST = 0;
  // Byte two
  localparam int unsigned XSYS_SWITCH_IN = 7;
  localparam int unsigned XSYS_FB_CAL = 6;
  localparam int unsigned XSYS_LOOP_CAL = 5;
  localparam int unsigned XSYS_CYCLE_LIMIT = 4;
  localparam int unsigned XSYS_TRAVEL_LIMIT = 3;
  localparam int unsigned XSYS_BAD_CONFIG = 2;
  localparam int unsigned XSYS_TEMP_LOW = 1;
  localparam int unsigned XSYS_TEMP_HIGH = 0;
  // Byte three
  localparam int unsigned PROC_OUT_PRESS = 7;
  localparam int unsigned PROC_SUPPLY_LOW = 6;
  localparam int unsigned PROC_AUTOSTART = 5;
  localparam int unsigned PROC_DEVIATION = 4;
  localparam int unsigned PROC_VERY_LOW = 3;
  localparam int unsigned PROC_VERY_HIGH = 2;
  localparam int unsigned PROC_LOW = 1;
  localparam int unsigned PROC_HIGH = 0;
endpackage

// ==== verification/pdsb_bank_sva.sv ====
// Purpose: Port checks of the diagnosis bank
// Assumes: One clock, synchronous active-low reset
// Notes: Reads answer one cycle after the index is taken
`timescale 1ns/10ps
module pdsb_bank_chk #(
  parameter int unsigned VAL_W = 16,
  parameter int unsigned CNT_W = 24
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic option_board_fault,
  input wire logic [CNT_W-1:0] cycle_count,
  input wire logic [CNT_W-1:0] cycle_count_limit,
  input wire logic signed [VAL_W-1:0] board_temp,
  input wire logic signed [VAL_W-1:0] board_temp_floor,
  input wire logic signed [VAL_W-1:0] board_temp_ceiling,
  input wire logic [VAL_W-1:0] supply_pressure_reading,
  input wire logic [VAL_W-1:0] supply_pressure_threshold,
  input wire logic [2:0] rd_index,
  input wire logic [7:0] rd_data,
  input wire logic rd_error,
  input wire logic param_wr,
  input wire logic [15:0] param_wdata,
  input wire logic ext_set,
  input wire logic ext_available,
  input wire logic history_cleared
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire clr = param_wr && param_wdata == 16'h8000;
  wire cyc_hit = cycle_count >= cycle_count_limit;
  wire [1:0] temp_hit = {board_temp < board_temp_floor, board_temp > board_temp_ceiling};
  wire air_low = supply_pressure_reading < supply_pressure_threshold;
  rd_bad_a: assert property (rd_index > 3'h5 |=> rd_error && rd_data == 8'h00)
    else $error("unmapped index not refused");
  sys_live_a: assert property (rd_index == 3'h0 |=> rd_data[7] == $past(option_board_fault))
    else $error("live system byte wrong");
  cyc_lim_a: assert property (rd_index == 3'h1 |=> rd_data[4] == $past(cyc_hit))
    else $error("cycle limit bit wrong");
  temp_lim_a: assert property (rd_index == 3'h1 |=> rd_data[1:0] == $past(temp_hit))
    else $error("temperature bits wrong");
  air_low_a: assert property (rd_index == 3'h2 |=> rd_data[6] == $past(air_low))
    else $error("supply low bit wrong");
  hist_hold_a: assert property (rd_index == 3'h3 && option_board_fault |=> rd_data[7])
    else $error("history bit not set with event");
  clr_ok_a: assert property (clr |=> history_cleared && ext_available == $past(ext_set))
    else $error("clear write not honoured");
  no_clr_a: assert property (!clr |=> !history_cleared)
    else $error("clear without clearing write");
endmodule
bind pdsb_bank pdsb_bank_chk #(.VAL_W(VAL_W), .CNT_W(CNT_W)) pdsb_bank_chk_i (.*);

// ==== verification/pdsb_bank_tb.sv ====
// Purpose: Random run of the diagnosis bank with a burst of all single-bit faults
// Assumes: Master model owns the read and clear port
// Notes: Deviation time is random 0..2; a reset pulse is also applied mid-run
`timescale 1ns/10ps
module pdsb_bank_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] sf = 8'h00, xf = 8'h00, pf = 8'h00;
  logic [23:0] cc = 24'h0, ccl = 24'h0, hist = 24'h0, dtm = 24'h0;
  logic signed [15:0] tmp = 16'sh0, tfl = 16'sh0, tcl = 16'sh0;
  logic [15:0] sp = 16'h0, spt = 16'h0, dev = 16'h0, devl = 16'h0, param_wdata;
  logic ext_set = 1'b0, ext_m = 1'b0, param_wr, rd_error, ext_available, history_cleared;
  logic [2:0] rd_index;
  logic [7:0] rd_data;
  int err_total = 0, samples_checked = 0;
  always #2 clk = ~clk;
  pdsb_master_model pdsb_master_model_i (.clk(clk), .rd_index(rd_index), .param_wr(param_wr),
    .param_wdata(param_wdata));
  pdsb_bank pdsb_bank_i (.clk(clk), .rst_b(rst_b), .option_board_fault(sf[7]),
    .position_pot_fault(sf[6]), .transducer_loop_break(sf[5]), .actuator_out_of_span(sf[4]),
    .converter_fault(sf[3]), .rom_sum_fault(sf[2]), .nvm_sum_fault(sf[1]),
    .ram_test_fault(sf[0]), .switch_input_active(xf[7]), .feedback_cal_fault(xf[6]),
    .loop_cal_fault(xf[5]), .cycle_count(cc), .cycle_count_limit(ccl),
    .travel_sum_limit(xf[3]), .config_invalid(xf[2]), .board_temp(tmp),
    .board_temp_floor(tfl), .board_temp_ceiling(tcl), .output_pressure_implausible(pf[7]),
    .supply_pressure_reading(sp), .supply_pressure_threshold(spt), .autostart_failed(pf[5]),
    .control_deviation(dev), .deviation_limit(devl), .deviation_time(dtm),
    .position_very_low(pf[3]), .position_very_high(pf[2]), .position_low(pf[1]),
    .position_high(pf[0]), .rd_index(rd_index), .rd_data(rd_data), .rd_error(rd_error),
    .param_wr(param_wr), .param_wdata(param_wdata), .ext_set(ext_set),
    .ext_available(ext_available), .history_cleared(history_cleared));
  function automatic logic [23:0] live_exp();
    logic [7:0] x;
    logic [7:0] p;
    x = xf;
    x[4] = cc >= ccl;
    x[1] = tmp < tfl;
    x[0] = tmp > tcl;
    p = pf;
    p[6] = sp < spt;
    p[4] = dev > devl;
    return {p, x, sf};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    logic [23:0] lv;
    logic [23:0] hv;
    int dcnt;
    logic clr;
    logic [2:0] ix;
    logic hot;
    dcnt = 0;
    void'($urandom(32'h628059c3));
    for (int n = 0; n < 4000; n++) begin
      @(posedge clk);
      lv = live_exp();
      // Deviation must have stood above its limit for dtm earlier cycles
      lv[20] = (dev > devl) && (dcnt >= dtm);
      dcnt = (!rst_b || dev <= devl) ? 0 : dcnt + 1;
      clr = param_wr && param_wdata == 16'h8000;
      ix = rd_index;
      hv = hist | lv;
      hist = rst_b ? ((clr ? 24'h0 : hist) | lv) : 24'h0;
      ext_m = rst_b && (ext_set || (ext_m && !clr));
      #1;
      if (rst_b) begin
        if (ix > 3'h5) chk(rd_data, 8'h00);
        else if (ix < 3'h3) chk(rd_data, lv[8*ix +: 8]);
        else chk(rd_data, hv[8*(ix-3) +: 8]);
        chk({7'h0, rd_error}, {7'h0, ix > 3'h5});
        chk({7'h0, history_cleared}, {7'h0, clr});
        chk({7'h0, ext_available}, {7'h0, ext_m});
      end else begin
        chk(rd_data, 8'h00);
      end
      rst_b <= n >= 3 && !(n >= 3000 && n < 3004);
      hot = n >= 2000 && n < 2100;
      sf <= hot ? 8'hff : 8'($urandom & $urandom & $urandom);
      xf <= 8'hec & (hot ? 8'hff : 8'($urandom & $urandom & $urandom));
      pf <= 8'haf & (hot ? 8'hff : 8'($urandom & $urandom & $urandom));
      cc <= 24'($urandom % 4);
      ccl <= 24'($urandom % 4);
      tmp <= 16'($urandom % 5) - 16'sd2;
      tfl <= 16'($urandom % 5) - 16'sd2;
      tcl <= 16'($urandom % 5) - 16'sd2;
      sp <= 16'($urandom % 4);
      spt <= 16'($urandom % 4);
      dev <= 16'($urandom % 4);
      devl <= 16'($urandom % 4);
      dtm <= 24'($urandom % 3);
      ext_set <= ($urandom % 16) == 0;
    end
    stop_test();
  end
endmodule

// ==== verification/pdsb_master_model.sv ====
// Purpose: Fieldbus master reading bytes and writing the clear parameter
// Assumes: Drives just after each rising edge
// Notes: Half of its writes carry the clearing value
`timescale 1ns/10ps
module pdsb_master_model (
  input wire logic clk,
  output logic [2:0] rd_index,
  output logic param_wr,
  output logic [15:0] param_wdata
);
  initial begin
    rd_index = 3'h0;
    param_wr = 1'b0;
    param_wdata = 16'h0000;
  end
  always @(posedge clk) begin
    #1;
    rd_index <= 3'($urandom);
    param_wr <= ($urandom % 6) == 0;
    param_wdata <= ($urandom % 2) ? 16'h8000 : 16'($urandom);
  end
endmodule
